// ==== verilog/ues_pkg.sv ====
`default_nettype none
package ues_pkg;
    // device register offsets
    localparam logic [7:0] ADDR_IRQ_EN   = 8'hc2;
    localparam logic [7:0] ADDR_FIFO_RST = 8'hd5;
    localparam logic [7:0] ADDR_EP_STAT0 = 8'hc4;
    localparam logic [7:0] ADDR_EP_INT   = 8'hc7;
    // endpoint status bit positions
    localparam int BIT_TXC   = 0;
    localparam int BIT_OUTB0 = 1;
    localparam int BIT_SETUP = 2;
    localparam int BIT_IN_PACKET_READY = 4;
    localparam int NUM_EP    = 3;
    localparam logic [7:0] REG_RESET  = 8'h00;
    localparam logic [7:0] FIFO_MASK  = 8'h07;
    // write patterns: a txc, outb0 or setup bit written 0 is cleared; a ready bit written 1 is set
    localparam logic [7:0] KEEP_FLAGS = 8'h07;
    localparam logic [7:0] CLR_OUTB0  = 8'h05;
    localparam logic [7:0] CLR_TXC    = 8'h06;
    localparam logic [7:0] SET_IN_PACKET_READY  = 8'h17;
    // controller register offsets
    localparam logic [7:0] C_CMD      = 8'h00;
    localparam logic [7:0] C_STAT     = 8'h01;
    localparam logic [7:0] C_RAW_ADDR = 8'h02;
    localparam logic [7:0] C_RAW_DATA = 8'h03;
    localparam logic [7:0] C_IRQ_STAT = 8'h04;
    localparam logic [7:0] C_IRQ_CLR  = 8'h05;
    localparam logic [7:0] C_IRQ_EN   = 8'h06;
    localparam int CMD_OP_LSB = 5;
    localparam int IRQ_DEV  = 0;
    localparam int IRQ_DONE = 1;
    localparam int IRQ_INIT = 2;
    typedef enum logic [2:0] {
        OP_NONE, OP_INIT, OP_CLR_OUT, OP_ARM_IN, OP_RAW_RD, OP_RAW_WR
    } ues_op_t;

    // address of one endpoint's status register
    function automatic logic [7:0] stat_addr(input logic [1:0] ep);
        stat_addr = ADDR_EP_STAT0 + {6'h00, ep};
    endfunction : stat_addr
endpackage : ues_pkg
`default_nettype wire

// ==== verilog/ues_if.sv ====
`timescale 1ns/100ps
`default_nettype none
interface ues_if;
    logic [7:0] sfr_addr;
    logic [7:0] sfr_wdata;
    logic       sfr_wr;
    logic       sfr_rd;
    logic [7:0] sfr_rdata;
    logic       ep_irq;
    logic       bus_rst;
    modport dev (input sfr_addr, sfr_wdata, sfr_wr, sfr_rd,
                 output sfr_rdata, ep_irq, bus_rst);
    modport fw  (output sfr_addr, sfr_wdata, sfr_wr, sfr_rd,
                 input sfr_rdata, ep_irq, bus_rst);
endinterface : ues_if
`default_nettype wire

// ==== verilog/ues_dev.sv ====
`timescale 1ns/100ps
`default_nettype none
// Operation
// (RQ1) set out flag when bank0 packet stored
// (RQ2) nak out packets while flag set, not iso
// (RQ3) setup may overwrite fifo despite out flag
// (RQ4) firmware clears out flag after reading data
// (RQ5) iso: transmit complete when packet sent
// (RQ6) others: transmit complete after host ack
// (RQ7) flags raise interrupt only when enabled
// (RQ8) firmware clears complete before rearming ready
// (RQ9) status and fifo reset regs reset zero
// (RQ10) fifo reset bit n clears endpoint n
// (RQ11) firmware pulses fifo resets after any reset
// (RQ12) reserved fifo reset bits read zero
// (RQ13) firmware never writes reserved reset bits
// (RQ14) setup sets its flag, clears others
// (RQ15) hardware clears ready when sent or acked
// (RQ16) fifo pointer held empty during reset bit
module ues_dev #(
    parameter int PTR_W = 6
) (
    // clock and reset
    input  wire logic                    core_clk,
    input  wire logic                    rst_n,
    // register side towards the controller
    ues_if.dev                           sfr,
    // usb engine events, one-cycle pulses
    input  wire logic [1:0]              ev_ep,
    input  wire logic                    ev_out_stored,
    input  wire logic                    ev_in_sent,
    input  wire logic                    ev_in_acked,
    input  wire logic                    ev_setup,
    input  wire logic                    ev_setup_start,
    input  wire logic                    ev_byte_stored,
    input  wire logic                    usb_bus_reset,
    // endpoint types, static
    input  wire logic [2:0]              ep_iso,
    input  wire logic [2:0]              ep_ctrl,
    // outputs to the usb engine
    output var  logic [2:0]              out_nak_ff,
    output var  logic [2:0]              fifo_hold_ff,
    output var  logic [3*PTR_W-1:0]      fifo_ptr_ff
);
    localparam int N = ues_pkg::NUM_EP;

    // refuse pointer widths the counters cannot serve
    if (PTR_W < 1 || PTR_W > 16)
    begin : g_bad_ptr_w
        $error("ues_dev: PTR_W out of range");
    end

    logic [N-1:0]     txc_ff;
    logic [N-1:0]     outb0_ff;
    logic [N-1:0]     setup_ff;
    logic [N-1:0]     in_packet_ready_ff;
    logic [2:0]       irq_en_ff;
    logic [2:0]       fifo_rst_ff;
    logic [7:0]       rdata_ff;
    logic             irq_ff;
    logic             bus_rst_ff;
    logic [PTR_W-1:0] ptr_ff [N];
    logic [N-1:0]     nxt_txc;
    logic [N-1:0]     nxt_outb0;
    logic [N-1:0]     nxt_setup;
    logic [N-1:0]     nxt_in_packet_ready;
    logic [PTR_W-1:0] nxt_ptr [N];
    logic [7:0]       nxt_rdata;

    // per-endpoint event decode
    wire logic [N-1:0] sel;
    wire logic [N-1:0] hit;
    wire logic [N-1:0] in_done;
    wire logic [N-1:0] ep_int;
    genvar g;
    for (g = 0; g < N; g++)
    begin : g_dec
        assign sel[g] = (ev_ep == 2'(g));
        assign hit[g] = sfr.sfr_wr && (sfr.sfr_addr == ues_pkg::stat_addr(2'(g)));
        assign in_done[g] = sel[g] && (ep_iso[g] ? ev_in_sent : ev_in_acked); // RQ5 RQ6
        assign ep_int[g] = txc_ff[g] | outb0_ff[g] | setup_ff[g];
    end

    wire logic wr_ien = sfr.sfr_wr && (sfr.sfr_addr == ues_pkg::ADDR_IRQ_EN);
    wire logic wr_rst = sfr.sfr_wr && (sfr.sfr_addr == ues_pkg::ADDR_FIFO_RST);
    wire logic [7:0] wd = sfr.sfr_wdata;

    // flag next state; a hardware set wins over a firmware clear
    always_comb
    begin
        for (int e = 0; e < N; e++)
        begin
            nxt_txc[e]   = txc_ff[e];
            nxt_outb0[e] = outb0_ff[e];
            nxt_setup[e] = setup_ff[e];
            nxt_in_packet_ready[e] = in_packet_ready_ff[e];
            if (hit[e] && !wd[ues_pkg::BIT_TXC])
                nxt_txc[e] = 1'b0;
            if (hit[e] && !wd[ues_pkg::BIT_OUTB0])
                nxt_outb0[e] = 1'b0; // RQ4
            if (hit[e] && !wd[ues_pkg::BIT_SETUP])
                nxt_setup[e] = 1'b0;
            if (in_done[e])
            begin
                nxt_txc[e]   = 1'b1; // RQ5 RQ6
                nxt_in_packet_ready[e] = 1'b0; // RQ15
            end
            if (sel[e] && ev_out_stored)
                nxt_outb0[e] = 1'b1; // RQ1
            if (sel[e] && ev_setup)
            begin
                nxt_setup[e] = 1'b1; // RQ14
                nxt_txc[e]   = 1'b0; // RQ14
                nxt_outb0[e] = 1'b0; // RQ14
                nxt_in_packet_ready[e] = 1'b0; // RQ14
            end
            // firmware arming the next packet wins over a same-cycle clear
            if (hit[e] && wd[ues_pkg::BIT_IN_PACKET_READY])
                nxt_in_packet_ready[e] = 1'b1;
        end
    end

    // fifo write pointers; a setup may restart a full bank
    always_comb
    begin
        for (int e = 0; e < N; e++)
        begin
            nxt_ptr[e] = ptr_ff[e];
            if (fifo_rst_ff[e])
                nxt_ptr[e] = '0; // RQ16 RQ10
            else if (sel[e] && ev_setup_start && ep_ctrl[e])
                nxt_ptr[e] = '0; // RQ3
            else if (sel[e] && ev_byte_stored)
                nxt_ptr[e] = ptr_ff[e] + PTR_W'(1);
        end
    end

    // read mux; reserved bits read as zero
    always_comb
    begin
        nxt_rdata = 8'h00;
        if (sfr.sfr_rd)
        begin
            if (sfr.sfr_addr == ues_pkg::ADDR_IRQ_EN)
                nxt_rdata = {5'h00, irq_en_ff};
            else if (sfr.sfr_addr == ues_pkg::ADDR_FIFO_RST)
                nxt_rdata = {5'h00, fifo_rst_ff}; // RQ12
            else if (sfr.sfr_addr == ues_pkg::ADDR_EP_INT)
                nxt_rdata = {5'h00, ep_int};
            for (int e = 0; e < N; e++)
            begin
                if (sfr.sfr_addr == ues_pkg::stat_addr(2'(e)))
                    nxt_rdata = {3'h0, in_packet_ready_ff[e], 1'b0, setup_ff[e],
                                 outb0_ff[e], txc_ff[e]};
            end
        end
    end

    // status flags
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            txc_ff   <= '0; // RQ9
            outb0_ff <= '0; // RQ9
            setup_ff <= '0; // RQ9
            in_packet_ready_ff <= '0; // RQ9
        end
        else
        begin
            txc_ff   <= nxt_txc;
            outb0_ff <= nxt_outb0;
            setup_ff <= nxt_setup;
            in_packet_ready_ff <= nxt_in_packet_ready;
        end
    end

    // control registers and read data
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            irq_en_ff   <= '0;
            fifo_rst_ff <= '0; // RQ9
            rdata_ff    <= ues_pkg::REG_RESET;
            bus_rst_ff  <= 1'b0;
        end
        else
        begin
            if (wr_ien)
                irq_en_ff <= wd[2:0];
            if (wr_rst)
                fifo_rst_ff <= wd[2:0]; // RQ10
            rdata_ff   <= nxt_rdata;
            bus_rst_ff <= usb_bus_reset;
        end
    end

    // nak, hold, interrupt and pointers all registered
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            out_nak_ff   <= '0;
            fifo_hold_ff <= '0;
            irq_ff       <= 1'b0;
            for (int e = 0; e < N; e++)
                ptr_ff[e] <= '0;
        end
        else
        begin
            out_nak_ff   <= nxt_outb0 & ~ep_iso; // RQ2
            fifo_hold_ff <= fifo_rst_ff; // RQ16
            irq_ff       <= |(ep_int & irq_en_ff); // RQ7
            for (int e = 0; e < N; e++)
                ptr_ff[e] <= nxt_ptr[e];
        end
    end

    for (g = 0; g < N; g++)
    begin : g_ptr
        assign fifo_ptr_ff[g*PTR_W +: PTR_W] = ptr_ff[g];
    end

    assign sfr.sfr_rdata = rdata_ff;
    assign sfr.ep_irq    = irq_ff;
    assign sfr.bus_rst   = bus_rst_ff;
endmodule : ues_dev
`default_nettype wire

// ==== verilog/ues_ctl.sv ====
`timescale 1ns/100ps
`default_nettype none
module ues_ctl (
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    // device register side
    ues_if.fw               sfr,
    // software port
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output var  logic [7:0] rdata_ff,
    output var  logic       irq_ff
);
    typedef enum logic [1:0] {ST_IDLE, ST_STEP2, ST_RDWAIT, ST_RDTAKE} ues_st_t;

    ues_st_t              st_ff;
    ues_st_t              nxt_st;
    ues_pkg::ues_op_t     op_ff;
    ues_pkg::ues_op_t     nxt_op;
    logic                 init_pend_ff;
    logic [7:0]           raw_addr_ff;
    logic [7:0]           raw_data_ff;
    logic [2:0]           ist_ff;
    logic [2:0]           ien_ff;
    logic                 dev_irq_d_ff;
    logic [7:0]           a_ff;
    logic [7:0]           d_ff;
    logic                 w_ff;
    logic                 r_ff;
    logic [7:0]           nxt_a;
    logic [7:0]           nxt_d;
    logic                 nxt_w;
    logic                 nxt_r;
    logic                 done;
    logic                 init_start;

    wire logic busy    = (st_ff != ST_IDLE) || init_pend_ff;
    wire logic cmd_wr  = wr && (addr == ues_pkg::C_CMD) && !busy;
    wire ues_pkg::ues_op_t cmd_op = ues_pkg::ues_op_t'(wdata[7:ues_pkg::CMD_OP_LSB]);
    wire logic [1:0] cmd_ep = wdata[1:0];
    // reserved fifo reset bits are never written
    wire logic [7:0] raw_wd = (raw_addr_ff == ues_pkg::ADDR_FIFO_RST)
                            ? (raw_data_ff & ues_pkg::FIFO_MASK) : raw_data_ff; // RQ13

    // sequencer: first access leaves idle, second follows at once
    always_comb
    begin
        nxt_st = st_ff;
        nxt_op = op_ff;
        nxt_a = a_ff;
        nxt_d = d_ff;
        nxt_w = 1'b0;
        nxt_r = 1'b0;
        done = 1'b0;
        init_start = 1'b0;
        case (st_ff)
            ST_IDLE:
            begin
                if (init_pend_ff)
                begin
                    init_start = 1'b1;
                    nxt_op = ues_pkg::OP_INIT;
                    nxt_a = ues_pkg::ADDR_FIFO_RST;
                    nxt_d = ues_pkg::FIFO_MASK; // RQ11 RQ13
                    nxt_w = 1'b1;
                    nxt_st = ST_STEP2;
                end
                else if (cmd_wr)
                begin
                    nxt_op = cmd_op;
                    nxt_a = ues_pkg::stat_addr(cmd_ep);
                    nxt_st = ST_IDLE;
                    case (cmd_op)
                        ues_pkg::OP_CLR_OUT:
                        begin
                            nxt_d = ues_pkg::CLR_OUTB0; // RQ4
                            nxt_w = 1'b1;
                        end
                        ues_pkg::OP_ARM_IN:
                        begin
                            nxt_d = ues_pkg::CLR_TXC; // RQ8
                            nxt_w = 1'b1;
                            nxt_st = ST_STEP2;
                        end
                        ues_pkg::OP_RAW_RD:
                        begin
                            nxt_a = raw_addr_ff;
                            nxt_r = 1'b1;
                            nxt_st = ST_RDWAIT;
                        end
                        ues_pkg::OP_RAW_WR:
                        begin
                            nxt_a = raw_addr_ff;
                            nxt_d = raw_wd;
                            nxt_w = 1'b1;
                        end
                        default:
                            nxt_a = a_ff;
                    endcase
                    done = (nxt_st == ST_IDLE);
                end
            end
            ST_STEP2:
            begin
                nxt_w = 1'b1;
                nxt_st = ST_IDLE;
                done = 1'b1;
                if (op_ff == ues_pkg::OP_INIT)
                    nxt_d = 8'h00; // RQ11
                else
                    nxt_d = ues_pkg::SET_IN_PACKET_READY; // RQ8
            end
            // the device answers the cycle after the strobe; take it then
            ST_RDWAIT:
                nxt_st = ST_RDTAKE;
            ST_RDTAKE:
            begin
                nxt_st = ST_IDLE;
                done = 1'b1;
            end
            default:
                nxt_st = ST_IDLE;
        endcase
    end

    // sequencer state and device bus outputs
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            st_ff <= ST_IDLE;
            op_ff <= ues_pkg::OP_NONE;
            a_ff  <= 8'h00;
            d_ff  <= 8'h00;
            w_ff  <= 1'b0;
            r_ff  <= 1'b0;
        end
        else
        begin
            st_ff <= nxt_st;
            op_ff <= nxt_op;
            a_ff  <= nxt_a;
            d_ff  <= nxt_d;
            w_ff  <= nxt_w;
            r_ff  <= nxt_r;
        end
    end

    wire logic [2:0] ev = {done && op_ff == ues_pkg::OP_INIT && st_ff == ST_STEP2,
                           done, sfr.ep_irq && !dev_irq_d_ff};
    wire logic clr_hit = wr && (addr == ues_pkg::C_IRQ_CLR);

    // software registers, pending init and sticky events
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            init_pend_ff <= 1'b1; // RQ11
            raw_addr_ff  <= 8'h00;
            raw_data_ff  <= 8'h00;
            ist_ff       <= 3'h0;
            ien_ff       <= 3'h0;
            dev_irq_d_ff <= 1'b0;
            irq_ff       <= 1'b0;
        end
        else
        begin
            init_pend_ff <= sfr.bus_rst || (cmd_wr && cmd_op == ues_pkg::OP_INIT)
                            || (init_pend_ff && !init_start); // RQ11
            if (wr && addr == ues_pkg::C_RAW_ADDR)
                raw_addr_ff <= wdata;
            if (st_ff == ST_RDTAKE)
                raw_data_ff <= sfr.sfr_rdata;
            else if (wr && addr == ues_pkg::C_RAW_DATA)
                raw_data_ff <= wdata;
            if (wr && addr == ues_pkg::C_IRQ_EN)
                ien_ff <= wdata[2:0];
            // a new event wins over a clear in the same cycle
            ist_ff <= (ist_ff & ~(clr_hit ? wdata[2:0] : 3'h0)) | ev;
            dev_irq_d_ff <= sfr.ep_irq;
            irq_ff <= |(ist_ff & ien_ff);
        end
    end

    // read data one cycle after the strobe
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            rdata_ff <= 8'h00;
        else if (!rd)
            rdata_ff <= 8'h00;
        else
        begin
            case (addr)
                ues_pkg::C_STAT:     rdata_ff <= {6'h00, init_pend_ff, busy};
                ues_pkg::C_RAW_ADDR: rdata_ff <= raw_addr_ff;
                ues_pkg::C_RAW_DATA: rdata_ff <= raw_data_ff;
                ues_pkg::C_IRQ_STAT: rdata_ff <= {5'h00, ist_ff};
                ues_pkg::C_IRQ_EN:   rdata_ff <= {5'h00, ien_ff};
                default:             rdata_ff <= 8'h00;
            endcase
        end
    end

    assign sfr.sfr_addr  = a_ff;
    assign sfr.sfr_wdata = d_ff;
    assign sfr.sfr_wr    = w_ff;
    assign sfr.sfr_rd    = r_ff;
endmodule : ues_ctl
`default_nettype wire

// ==== test/ues_sva.sv ====
`timescale 1ns/100ps
`default_nettype none
module ues_sva (
    // clock and reset
    input wire logic       core_clk,
    input wire logic       rst_n,
    // device register port
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic       sfr_wr,
    input wire logic       sfr_rd,
    input wire logic [7:0] sfr_rdata,
    input wire logic       ep_irq,
    input wire logic       bus_rst
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // strobe shape on the register port
    a_strobe_excl: assert property (!(sfr_wr && sfr_rd))
        else $error("write and read strobe together");
    a_rd_single: assert property (sfr_rd |=> !sfr_rd)
        else $error("read strobe longer than one cycle");
    // read data stand only in the cycle after a read
    a_rdata_idle: assert property (!$past(sfr_rd) |-> sfr_rdata == 8'h00)
        else $error("read data outside read answer");
    a_unmapped_zero: assert property (sfr_rd && !(sfr_addr inside {8'hc2, 8'hc4, 8'hc5,
        8'hc6, 8'hc7, 8'hd5}) |=> sfr_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_fifo_rsvd: assert property (sfr_rd && sfr_addr == ues_pkg::ADDR_FIFO_RST |=>
        sfr_rdata[7:3] == 5'h00) else $error("reserved fifo reset bits not zero");
    // set then clear of all fifo resets, back to back
    a_init_pair: assert property (sfr_wr && sfr_addr == ues_pkg::ADDR_FIFO_RST &&
        sfr_wdata == ues_pkg::FIFO_MASK |=> sfr_wr && sfr_addr == ues_pkg::ADDR_FIFO_RST
        && sfr_wdata == 8'h00) else $error("fifo reset not released");
    a_bus_reinit: assert property ($rose(bus_rst) |-> ##[0:16] (sfr_wr &&
        sfr_addr == ues_pkg::ADDR_FIFO_RST && sfr_wdata == ues_pkg::FIFO_MASK))
        else $error("no fifo reset after bus reset");
    // ready is only set right after the complete flag was cleared
    a_txc_first: assert property (sfr_wr && sfr_wdata == ues_pkg::SET_IN_PACKET_READY |->
        $past(sfr_wr) && $past(sfr_wdata) == ues_pkg::CLR_TXC
        && $past(sfr_addr) == sfr_addr) else $error("ready set before complete cleared");
endmodule : ues_sva
`default_nettype wire

// ==== test/usb_endpoint_status_fifo_reset_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module usb_endpoint_status_fifo_reset_tb;
    localparam int PW = 6;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [6:0] ev = 7'h00;
    logic [1:0] ev_ep = 2'h0;
    logic [2:0] iso = 3'h0;
    logic [2:0] ctrl = 3'h1;
    logic [7:0] sw_rdata;
    logic sw_irq;
    logic [2:0] nak;
    logic [2:0] hold;
    logic [3*PW-1:0] ptr;
    logic [7:0] seed = 8'h61;
    logic [7:0] d;
    logic [2:0] en;
    int bad_count = 0;
    int samples_checked = 0;

    ues_if ifc ();
    ues_dev #(.PTR_W(PW)) ues_dev_i (.core_clk(core_clk), .rst_n(rst_n), .sfr(ifc),
        .ev_ep(ev_ep), .ev_out_stored(ev[0]), .ev_in_sent(ev[1]), .ev_in_acked(ev[2]),
        .ev_setup(ev[3]), .ev_setup_start(ev[4]), .ev_byte_stored(ev[5]),
        .usb_bus_reset(ev[6]), .ep_iso(iso), .ep_ctrl(ctrl), .out_nak_ff(nak),
        .fifo_hold_ff(hold), .fifo_ptr_ff(ptr));
    ues_ctl ues_ctl_i (.core_clk(core_clk), .rst_n(rst_n), .sfr(ifc), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata_ff(sw_rdata), .irq_ff(sw_irq));
    ues_sva ues_sva_i (.core_clk(core_clk), .rst_n(rst_n), .sfr_addr(ifc.sfr_addr),
        .sfr_wdata(ifc.sfr_wdata), .sfr_wr(ifc.sfr_wr), .sfr_rd(ifc.sfr_rd),
        .sfr_rdata(ifc.sfr_rdata), .ep_irq(ifc.ep_irq), .bus_rst(ifc.bus_rst));

    // 25 mhz clock
    initial
    begin
        forever #20 core_clk = ~core_clk;
    end

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr
    // iso ends complete on send, others wait for the ack
    function automatic logic [7:0] in_stat(input logic is_iso, input logic acked);
        in_stat = (is_iso || acked) ? 8'h01 : 8'h10;
    endfunction : in_stat

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
        samples_checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : chk
    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : stop_test
    // software port cycles
    task automatic sw_wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge core_clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge core_clk);
        wr <= 1'b0;
    endtask : sw_wr
    task automatic sw_rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge core_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge core_clk);
        rd <= 1'b0;
        #1 v = sw_rdata;
    endtask : sw_rd
    // poll busy under a bound; commands while busy are dropped
    task automatic idle();
        logic [7:0] s;
        s = 8'h01;
        for (int i = 0; i < 40 && s[0] !== 1'b0; i++)
            sw_rd(ues_pkg::C_STAT, s);
        chk(s & 8'h01, 8'h00, "still busy");
    endtask : idle
    task automatic cmd(input ues_pkg::ues_op_t op, input logic [1:0] ep);
        sw_wr(ues_pkg::C_CMD, {op, 3'h0, ep});
        idle();
    endtask : cmd
    task automatic raw_wr(input logic [7:0] a, input logic [7:0] v);
        sw_wr(ues_pkg::C_RAW_ADDR, a);
        sw_wr(ues_pkg::C_RAW_DATA, v);
        cmd(ues_pkg::OP_RAW_WR, 2'h0);
    endtask : raw_wr
    task automatic raw_rd(input logic [7:0] a, output logic [7:0] v);
        sw_wr(ues_pkg::C_RAW_ADDR, a);
        cmd(ues_pkg::OP_RAW_RD, 2'h0);
        sw_rd(ues_pkg::C_RAW_DATA, v);
    endtask : raw_rd
    // one-cycle usb engine event, then let flags and irq settle
    task automatic pulse(input int k, input logic [1:0] ep);
        @(posedge core_clk);
        ev <= 7'(1 << k);
        ev_ep <= ep;
        @(posedge core_clk);
        ev <= 7'h00;
        repeat (4) @(posedge core_clk);
        #1;
    endtask : pulse

    // watchdog, well past the expected few hundred cycles
    initial
    begin
        repeat (20000) @(posedge core_clk);
        bad_count++;
        stop_test();
    end

    initial
    begin
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        seed = lfsr(seed);
        iso <= seed[2:0];
        seed = lfsr(seed);
        en = seed[2:0];
        repeat (4) @(posedge core_clk);
        idle();
        for (int e = 0; e < 3; e++)
        begin
            raw_rd(ues_pkg::ADDR_EP_STAT0 + 8'(e), d);
            chk(d, 8'h00, "status reset");
        end
        raw_rd(ues_pkg::ADDR_FIFO_RST, d);
        chk(d, 8'h00, "fifo reset reset");
        raw_wr(ues_pkg::ADDR_IRQ_EN, {5'h00, en});
        for (int e = 0; e < 3; e++)
        begin
            pulse(0, 2'(e));
            raw_rd(ues_pkg::ADDR_EP_STAT0 + 8'(e), d);
            chk(d, 8'h02, "out flag");
            chk({7'h00, nak[e]}, {7'h00, ~iso[e]}, "nak");
            chk({7'h00, ifc.ep_irq}, {7'h00, en[e]}, "ep irq");
            raw_rd(ues_pkg::ADDR_EP_INT, d);
            chk(d, 8'(1 << e), "pending flags");
            cmd(ues_pkg::OP_CLR_OUT, 2'(e));
            raw_rd(ues_pkg::ADDR_EP_STAT0 + 8'(e), d);
            chk(d, 8'h00, "out cleared");
            chk({7'h00, nak[e]}, 8'h00, "nak released");
            cmd(ues_pkg::OP_ARM_IN, 2'(e));
            pulse(1, 2'(e));
            raw_rd(ues_pkg::ADDR_EP_STAT0 + 8'(e), d);
            chk(d, in_stat(iso[e], 1'b0), "in sent");
            pulse(2, 2'(e));
            raw_rd(ues_pkg::ADDR_EP_STAT0 + 8'(e), d);
            chk(d, in_stat(iso[e], 1'b1), "in acked");
            cmd(ues_pkg::OP_ARM_IN, 2'(e));
            pulse(0, 2'(e));
            pulse(3, 2'(e));
            raw_rd(ues_pkg::ADDR_EP_STAT0 + 8'(e), d);
            chk(d, 8'h04, "setup");
            raw_wr(ues_pkg::ADDR_EP_STAT0 + 8'(e), 8'h00);
            pulse(5, 2'(e));
            pulse(5, 2'(e));
            chk({2'h0, ptr[e*PW +: PW]}, 8'h02, "pointer count");
            raw_wr(ues_pkg::ADDR_FIFO_RST, 8'(1 << e));
            chk({5'h00, hold}, 8'(1 << e), "fifo hold");
            chk({2'h0, ptr[e*PW +: PW]}, 8'h00, "pointer held");
            raw_wr(ues_pkg::ADDR_FIFO_RST, 8'h00);
        end
        // early setup on the control endpoint overrides a full bank
        pulse(0, 2'h0);
        pulse(5, 2'h0);
        pulse(4, 2'h0);
        chk({2'h0, ptr[PW-1:0]}, 8'h00, "setup start");
        raw_wr(ues_pkg::ADDR_EP_STAT0, 8'h00);
        raw_wr(ues_pkg::ADDR_FIFO_RST, 8'hfa);
        raw_rd(ues_pkg::ADDR_FIFO_RST, d);
        chk(d, 8'h02, "reserved bits");
        raw_wr(ues_pkg::ADDR_FIFO_RST, 8'h00);
        raw_rd(8'h10, d);
        chk(d, 8'h00, "unmapped device");
        sw_rd(8'h30, d);
        chk(d, 8'h00, "unmapped port");
        // interrupt raised, cleared, then masked
        raw_wr(ues_pkg::ADDR_IRQ_EN, 8'h01);
        sw_wr(ues_pkg::C_IRQ_CLR, 8'hff);
        sw_wr(ues_pkg::C_IRQ_EN, 8'h01);
        pulse(0, 2'h0);
        chk({7'h00, sw_irq}, 8'h01, "irq raised");
        raw_wr(ues_pkg::ADDR_EP_STAT0, 8'h00);
        sw_wr(ues_pkg::C_IRQ_CLR, 8'h01);
        @(posedge core_clk);
        #1 chk({7'h00, sw_irq}, 8'h00, "irq cleared");
        sw_wr(ues_pkg::C_IRQ_EN, 8'h00);
        pulse(0, 2'h0);
        sw_rd(ues_pkg::C_IRQ_STAT, d);
        chk({6'h00, d[0], sw_irq}, 8'h02, "irq masked");
        // init by command, then by usb bus reset; each reports init done
        sw_wr(ues_pkg::C_IRQ_CLR, 8'hff);
        cmd(ues_pkg::OP_INIT, 2'h0);
        sw_rd(ues_pkg::C_IRQ_STAT, d);
        chk(d & 8'h04, 8'h04, "init command");
        sw_wr(ues_pkg::C_IRQ_CLR, 8'hff);
        pulse(6, 2'h0);
        idle();
        sw_rd(ues_pkg::C_IRQ_STAT, d);
        chk(d & 8'h04, 8'h04, "bus reset init done");
        raw_rd(ues_pkg::ADDR_FIFO_RST, d);
        chk(d, 8'h00, "bus reset init");
        stop_test();
    end
endmodule : usb_endpoint_status_fifo_reset_tb
`default_nettype wire
